//--- include/infrared_emitter_pkg.sv
// Package for the infrared envelope emitter: register indices, field positions,
// reset values and the emission state type.
// Assumes a Wishbone slave with 32-bit data, one register per aligned word.
package infrared_emitter_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_INFRARED_CONTROL   = 8'hd9;
    localparam logic [7:0] IDX_ENVELOPE_COUNT_HI  = 8'hda;
    localparam logic [7:0] IDX_ENVELOPE_COUNT_LO  = 8'hdb;
    localparam logic [7:0] IDX_CARRIER_CONTROL    = 8'hdc;
    localparam logic [7:0] IDX_CARRIER_PERIOD_LO  = 8'hdd;
    localparam logic [7:0] IDX_CARRIER_PERIOD_HI  = 8'hde;
    localparam logic [7:0] IDX_CARRIER_DUTY_LO    = 8'hb6;
    localparam logic [7:0] IDX_CARRIER_DUTY_HI    = 8'hb7;

    // Field positions
    localparam int BIT_INFRARED_SELECT    = 0;
    localparam int BIT_ENVELOPE_DONE      = 1;
    localparam int BIT_ENVELOPE_LEVEL     = 7;
    localparam int BIT_CARRIER_OE         = 0;
    localparam int BIT_CARRIER_ENABLE     = 7;
    localparam int POS_CARRIER_CLK_SEL    = 3;

    // Writable bit masks
    localparam logic [7:0] MASK_ENVELOPE_COUNT_HI = 8'hbf;
    localparam logic [7:0] MASK_CARRIER_CONTROL   = 8'hb9;
    localparam logic [7:0] MASK_TWELVE_BIT_HI     = 8'h0f;

    // Reset values
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [13:0] RST_COUNT   = 14'h0000;
    localparam logic [11:0] RST_PERIOD  = 12'h000;
    localparam logic [6:0]  RST_PRESCALE = 7'h00;
    localparam logic [1:0]  RST_STRENGTH = 2'h0;

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SEND,
        PH_DONE
    } phase_type;

endpackage

//--- src/infrared_envelope_emitter.sv
// Infrared envelope emitter with its carrier generator and Wishbone register slave.
// Assumes one clock mclk at 200 MHz; option straps are static but asynchronous.
// Overview of operation
// - Once started, envelopes run by hardware alone, counting carrier periods.
// - At envelope end, next count and level flag load from count registers.
// - Loaded zero count stops the waveform; high-sink pin then floats.
// - Loaded zero count with standard-sink pin drives that pin low.
// - Envelope done flag, control bit 1, set and cleared by hardware.
// - Infrared select acts only while carrier pin output enable is 1.
// - Infrared select 0 gives plain carrier, 1 gives envelope emission.
// - High-sink pin only drives low or floats; standard pin drives both.
// - Level flag 1 sends carrier, 0 keeps diode off, count times period.
// - Count is 14 bits: high register bits 5-0, low register bits 7-0.
// - Option chooses high-sink or standard-sink pin; high-sink has strength.
// - Carrier period is 12-bit period value times selected carrier clock.
// - Carrier runs only when enabled; pin driven only when output enabled.
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module infrared_envelope_emitter
    import infrared_emitter_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        emitter_pin_select,
    input  wire logic [1:0]  high_sink_strength,
    output logic      [1:0]  high_sink_strength_cfg,
    output logic             high_sink_pin_out,
    output logic             high_sink_pin_oe,
    output logic             standard_sink_pin_out,
    output logic             standard_sink_pin_oe
);

    typedef struct packed {
        logic        infrared_select;
        logic        envelope_done_flag;
        logic [7:0]  envelope_count_high;
        logic [7:0]  envelope_count_low;
        logic [7:0]  carrier_control;
        logic [7:0]  carrier_period_high;
        logic [7:0]  carrier_period_low;
        logic [7:0]  duty_high;
        logic [7:0]  duty_low;
        logic [6:0]  prescale;
        logic [11:0] period_count;
        phase_type   phase;
        logic [13:0] remaining;
        logic        level;
        logic        ack;
        logic [7:0]  rdata;
        logic        pin_sel_meta;
        logic        pin_sel;
        logic [1:0]  strength_meta;
        logic [1:0]  strength;
        logic        hs_oe;
        logic        std_oe;
        logic        std_out;
    } state_type;

    state_type st;
    state_type next_st;

    logic        car_en;
    logic        car_oe;
    logic [2:0]  clk_sel;
    logic [6:0]  prescale_top;
    logic [11:0] period;
    logic [11:0] duty;
    logic        carrier_wave;
    logic        period_end;
    logic        active;
    logic [13:0] loaded_count;
    logic        env_end;
    logic        req;
    logic        wr;
    logic [7:0]  idx;
    logic        emit_on;

    assign car_en       = st.carrier_control[BIT_CARRIER_ENABLE];
    assign car_oe       = st.carrier_control[BIT_CARRIER_OE];
    assign clk_sel      = st.carrier_control[POS_CARRIER_CLK_SEL +: 3];
    assign prescale_top = 7'((8'h01 << clk_sel) - 8'h01);
    assign period       = {st.carrier_period_high[3:0], st.carrier_period_low};
    assign duty         = {st.duty_high[3:0], st.duty_low};
    assign carrier_wave = car_en && (period_count_lt_duty());
    assign period_end   = car_en && (st.prescale == prescale_top) && (period != 12'h000)
                          && (st.period_count == 12'(period - 12'h001));
    assign active       = car_en && car_oe && st.infrared_select;
    assign loaded_count = {st.envelope_count_high[5:0], st.envelope_count_low};
    assign req          = wb_cyc_i && wb_stb_i && !st.ack;
    assign wr           = req && wb_we_i && wb_sel_i[0];
    assign idx          = wb_adr_i[9:2];

    function automatic logic period_count_lt_duty();
        return st.period_count < duty;
    endfunction

    always_comb begin
        next_st = st;
        env_end = 1'b0;
        emit_on = 1'b0;

        // Option straps pass two flops; only the second is used
        next_st.pin_sel_meta  = emitter_pin_select;
        next_st.pin_sel       = st.pin_sel_meta;
        next_st.strength_meta = high_sink_strength;
        next_st.strength      = st.strength_meta;

        // Bus slave: one wait state, unmapped reads zero
        next_st.ack = req;
        if (req) begin
            case (idx)
                IDX_INFRARED_CONTROL:  next_st.rdata = {6'h00, st.envelope_done_flag,
                                                       st.infrared_select};
                IDX_ENVELOPE_COUNT_HI: next_st.rdata = st.envelope_count_high;
                IDX_ENVELOPE_COUNT_LO: next_st.rdata = st.envelope_count_low;
                IDX_CARRIER_CONTROL:   next_st.rdata = st.carrier_control;
                IDX_CARRIER_PERIOD_LO: next_st.rdata = st.carrier_period_low;
                IDX_CARRIER_PERIOD_HI: next_st.rdata = st.carrier_period_high;
                IDX_CARRIER_DUTY_LO:   next_st.rdata = st.duty_low;
                IDX_CARRIER_DUTY_HI:   next_st.rdata = st.duty_high;
                default:               next_st.rdata = RST_BYTE;
            endcase
        end
        if (wr) begin
            case (idx)
                // The done flag belongs to hardware; software writes to it are dropped
                IDX_INFRARED_CONTROL:  next_st.infrared_select = wb_dat_i[BIT_INFRARED_SELECT];
                IDX_ENVELOPE_COUNT_HI: next_st.envelope_count_high =
                                           wb_dat_i[7:0] & MASK_ENVELOPE_COUNT_HI;
                IDX_ENVELOPE_COUNT_LO: next_st.envelope_count_low = wb_dat_i[7:0];
                IDX_CARRIER_CONTROL:   next_st.carrier_control =
                                           wb_dat_i[7:0] & MASK_CARRIER_CONTROL;
                IDX_CARRIER_PERIOD_LO: next_st.carrier_period_low = wb_dat_i[7:0];
                IDX_CARRIER_PERIOD_HI: next_st.carrier_period_high =
                                           wb_dat_i[7:0] & MASK_TWELVE_BIT_HI;
                IDX_CARRIER_DUTY_LO:   next_st.duty_low = wb_dat_i[7:0];
                IDX_CARRIER_DUTY_HI:   next_st.duty_high = wb_dat_i[7:0] & MASK_TWELVE_BIT_HI;
                default:               next_st.rdata = next_st.rdata;
            endcase
        end

        // Carrier generator: prescaler then 12-bit period counter
        if (!car_en) begin
            next_st.prescale     = RST_PRESCALE;
            next_st.period_count = RST_PERIOD;
        end else if (st.prescale == prescale_top) begin
            next_st.prescale = RST_PRESCALE;
            if (period_end || period == 12'h000) begin
                next_st.period_count = RST_PERIOD;
            end else begin
                next_st.period_count = 12'(st.period_count + 12'h001);
            end
        end else begin
            next_st.prescale = 7'(st.prescale + 7'h01);
        end

        // Flag clears when software writes the low count register or emission stops
        if ((wr && idx == IDX_ENVELOPE_COUNT_LO) || !active) begin
            next_st.envelope_done_flag = 1'b0;
        end

        case (st.phase)
            PH_IDLE: begin
                if (active) begin
                    next_st.remaining = loaded_count;
                    next_st.level     = st.envelope_count_high[BIT_ENVELOPE_LEVEL];
                    next_st.phase     = (loaded_count == RST_COUNT) ? PH_DONE : PH_SEND;
                end
            end
            PH_SEND: begin
                if (!active) begin
                    next_st.phase = PH_IDLE;
                end else if (period_end) begin
                    if (st.remaining == 14'h0001) begin
                        env_end                    = 1'b1;
                        next_st.envelope_done_flag = 1'b1;
                        next_st.remaining          = loaded_count;
                        next_st.level = st.envelope_count_high[BIT_ENVELOPE_LEVEL];
                        if (loaded_count == RST_COUNT) begin
                            next_st.phase = PH_DONE;
                        end
                    end else begin
                        next_st.remaining = 14'(st.remaining - 14'h0001);
                    end
                end
            end
            PH_DONE: begin
                if (!active) begin
                    next_st.phase = PH_IDLE;
                end
            end
            default: next_st.phase = PH_IDLE;
        endcase

        // Pin drive; a low envelope and a finished emission keep the diode dark
        if (car_oe) begin
            if (st.infrared_select) begin
                emit_on = (st.phase == PH_SEND) && st.level && carrier_wave;
            end else begin
                emit_on = carrier_wave;
            end
        end
        // High-sink pin sinks to light the diode, otherwise floats
        next_st.hs_oe   = car_oe && !st.pin_sel && emit_on;
        next_st.std_oe  = car_oe && st.pin_sel;
        next_st.std_out = emit_on;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{phase: PH_IDLE, remaining: RST_COUNT, period_count: RST_PERIOD,
                    prescale: RST_PRESCALE, strength_meta: RST_STRENGTH,
                    strength: RST_STRENGTH, envelope_count_high: RST_BYTE,
                    envelope_count_low: RST_BYTE, carrier_control: RST_BYTE,
                    carrier_period_high: RST_BYTE, carrier_period_low: RST_BYTE,
                    duty_high: RST_BYTE, duty_low: RST_BYTE, rdata: RST_BYTE,
                    default: 1'b0};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign wb_ack_o               = st.ack;
    assign wb_dat_o               = {24'h000000, st.rdata};
    assign high_sink_strength_cfg = st.strength;
    assign high_sink_pin_out      = 1'b0;
    assign high_sink_pin_oe       = st.hs_oe;
    assign standard_sink_pin_out  = st.std_out;
    assign standard_sink_pin_oe   = st.std_oe;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    AST_COUNT_DOWN: assert property (
        ce && st.phase == PH_SEND && active && period_end && st.remaining > 14'h0001
        |=> st.remaining == $past(st.remaining) - 14'h0001)
        else $error("Envelope count did not step down on a carrier period");

    AST_RELOAD: assert property (
        ce && env_end |=> st.remaining == $past(loaded_count)
        && st.level == $past(st.envelope_count_high[BIT_ENVELOPE_LEVEL]))
        else $error("Next envelope count not loaded at boundary");

    // Only while select stays on: dropping select hands the pin back to the plain carrier
    AST_ZERO_FLOATS: assert property (
        ce && st.phase == PH_DONE && st.infrared_select && !st.pin_sel |=> !high_sink_pin_oe)
        else $error("High-sink pin driven after emission end");

    AST_ZERO_DRIVES_LOW: assert property (
        ce && st.phase == PH_DONE && st.infrared_select && st.pin_sel && car_oe
        |=> standard_sink_pin_oe && !standard_sink_pin_out)
        else $error("Standard-sink pin not low after emission end");

    AST_FLAG_SET: assert property (
        ce && env_end |=> st.envelope_done_flag)
        else $error("Envelope done flag missed an envelope end");

    AST_SELECT_IGNORED: assert property (
        ce && !car_oe |=> !high_sink_pin_oe && !standard_sink_pin_oe)
        else $error("Pin driven while carrier pin output disabled");

    AST_PLAIN_CARRIER: assert property (
        ce && car_oe && !st.infrared_select |=> standard_sink_pin_out == $past(carrier_wave))
        else $error("Plain carrier not routed to pin");

    AST_HS_ONLY_LOW: assert property (
        high_sink_pin_oe |-> !high_sink_pin_out ##1 (!high_sink_pin_oe || !high_sink_pin_out))
        else $error("High-sink pin driven high");

    AST_LOW_ENVELOPE_DARK: assert property (
        ce && active && !st.level |=> !standard_sink_pin_out && !high_sink_pin_oe)
        else $error("Diode lit during low envelope");

    AST_GENERATOR_STOPPED: assert property (
        ce && !car_en |=> st.period_count == RST_PERIOD && st.prescale == RST_PRESCALE)
        else $error("Carrier generator ran while disabled");

    AST_IDLE_LOAD: assert property (
        ce && st.phase == PH_IDLE && active |=> st.remaining == $past(loaded_count))
        else $error("Start of emission did not sample the count registers");

    AST_ZERO_NO_SEND: assert property (
        ce && st.phase == PH_IDLE && active && loaded_count == RST_COUNT |=> st.phase == PH_DONE)
        else $error("Zero count at start still began an envelope");

    AST_PERIOD_WRAP: assert property (
        ce && period_end |=> st.period_count == RST_PERIOD)
        else $error("Carrier period counter did not wrap at period end");

    AST_FLAG_CLEAR: assert property (
        ce && !active |=> !st.envelope_done_flag)
        else $error("Envelope done flag held while emission inactive");

    AST_HS_DESELECTED: assert property (
        ce && st.pin_sel |=> !high_sink_pin_oe)
        else $error("High-sink pin driven while standard pin is emitter");

    AST_STD_DESELECTED: assert property (
        ce && !st.pin_sel |=> !standard_sink_pin_oe)
        else $error("Standard pin driven while high-sink pin is emitter");

    AST_DONE_DARK: assert property (
        ce && st.phase == PH_DONE && st.infrared_select
        |=> !standard_sink_pin_out && !high_sink_pin_oe)
        else $error("Diode lit after emission end");

    AST_HIGH_ENVELOPE_LIT: assert property (
        ce && car_oe && st.infrared_select && st.phase == PH_SEND && st.level
        |=> standard_sink_pin_out == $past(carrier_wave))
        else $error("High envelope did not carry the carrier");

    AST_EMISSION_STOPS: assert property (
        ce && st.phase != PH_IDLE && !active |=> st.phase == PH_IDLE)
        else $error("Emission kept running after it was switched off");

    AST_COUNT_MASK: assert property (
        ce && wr && idx == IDX_ENVELOPE_COUNT_HI |=> !st.envelope_count_high[6])
        else $error("Unused count bit became writable");

    COV_ENVELOPE_END: cover property (ce && env_end);
    COV_ZERO_END: cover property (ce && st.phase == PH_SEND ##1 st.phase == PH_DONE);
    COV_PLAIN_OUT: cover property (car_oe && !st.infrared_select && standard_sink_pin_out);
    COV_BUS_WRITE: cover property (wr && idx == IDX_ENVELOPE_COUNT_LO);

endmodule
`default_nettype wire

//--- dv/infrared_diode_model.sv
// Infrared diode hanging on whichever pin the strap picks as emitter.
// Assumes the high-sink pin has the diode to the supply, so a float reads high.
`timescale 1ns/1ps
`default_nettype none
module infrared_diode_model (
    input  wire logic        mclk,
    input  wire logic        hs_out,
    input  wire logic        hs_oe,
    input  wire logic        std_out,
    input  wire logic        std_oe,
    input  wire logic        pin_select,
    output logic             lit,
    output logic      [15:0] lit_edges,
    output logic             drove_high
);
    logic hs_level;
    logic lit_q = 1'b0;
    initial lit_edges = 16'h0000;
    initial drove_high = 1'b0;
    // Released pin is pulled up through the diode, never left at the last value
    assign hs_level = hs_oe ? hs_out : 1'b1;
    // Diode lights when its pin sinks (high-sink) or drives high (standard)
    assign lit = pin_select ? (std_oe & std_out) : ~hs_level;
    always @(posedge mclk) begin
        lit_q <= lit;
        if (lit && !lit_q) begin
            lit_edges <= lit_edges + 16'h0001;
        end
        // A sink-only pin must never source current into the diode
        if (hs_oe && hs_out) begin
            drove_high <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- dv/infrared_envelope_emitter_bench.sv
// Testbench for the infrared envelope emitter: Wishbone register tasks,
// envelope sequences and pin checks. Assumes the diode model in its own file.
`timescale 1ns/1ps
`default_nettype none
module infrared_envelope_emitter_bench;
    import infrared_emitter_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r, rd;
    logic        ack, strap = 1'b0;
    logic [1:0]  strength = 2'h2, strength_cfg;
    logic        hs_out, hs_oe, std_out, std_oe, lit, drove_high;
    logic [15:0] edges, e0;
    int          error_cnt = 0, samples_checked = 0;
    logic [7:0]  idx_list [9] = '{IDX_INFRARED_CONTROL, IDX_ENVELOPE_COUNT_HI,
        IDX_ENVELOPE_COUNT_LO, IDX_CARRIER_CONTROL, IDX_CARRIER_PERIOD_LO,
        IDX_CARRIER_PERIOD_HI, IDX_CARRIER_DUTY_LO, IDX_CARRIER_DUTY_HI, 8'h10};

    initial forever #2.5 mclk = ~mclk;

    infrared_envelope_emitter i_infrared_envelope_emitter (.mclk(mclk), .rst_b(rst_b),
        .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .emitter_pin_select(strap), .high_sink_strength(strength),
        .high_sink_strength_cfg(strength_cfg), .high_sink_pin_out(hs_out),
        .high_sink_pin_oe(hs_oe), .standard_sink_pin_out(std_out),
        .standard_sink_pin_oe(std_oe));
    infrared_diode_model i_infrared_diode_model (.mclk(mclk), .hs_out(hs_out),
        .hs_oe(hs_oe), .std_out(std_out), .std_oe(std_oe), .pin_select(strap),
        .lit(lit), .lit_edges(edges), .drove_high(drove_high));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask

    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1;
        adr <= {idx, 2'b00}; dat_w <= {24'h000000, wd};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        rd = dat_r;
        cyc <= 1'b0; stb <= 1'b0;
        if (n >= 100) check("bus ack", 32'h1, 32'h0);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Poll the control register until the done flag shows, bounded
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            bus(1'b0, IDX_INFRARED_CONTROL, 8'h00);
            n++;
        end while (rd[BIT_ENVELOPE_DONE] !== 1'b1 && n < 100);
        check("done flag", 32'h1, {31'h0, rd[BIT_ENVELOPE_DONE]});
    endtask

    // High envelope of 3, low of 2, then a zero count ends emission
    task automatic run_emission(input logic pin);
        strap <= pin;
        wait_cycles(4);
        check("strength cfg", 32'h2, {30'h0, strength_cfg});
        // Generator held off while set up, so no plain carrier leaks before emission
        wr(IDX_CARRIER_CONTROL, 8'h01);
        wr(IDX_ENVELOPE_COUNT_HI, 8'h80);
        wr(IDX_ENVELOPE_COUNT_LO, 8'h03);
        wr(IDX_INFRARED_CONTROL, 8'h01);
        e0 = edges;
        wr(IDX_CARRIER_CONTROL, 8'h81);
        wr(IDX_ENVELOPE_COUNT_HI, 8'h00);
        wr(IDX_ENVELOPE_COUNT_LO, 8'h02);
        wait_done();
        check("high envelope edges", 32'h3, {16'h0, edges - e0});
        wr(IDX_ENVELOPE_COUNT_LO, 8'h00);
        wait_done();
        wait_cycles(60);
        check("total edges", 32'h3, {16'h0, edges - e0});
        if (pin) check("std pin drive", 32'h2, {30'h0, std_oe, std_out});
        else check("hs pin float", 32'h0, {31'h0, hs_oe});
        bus(1'b0, IDX_INFRARED_CONTROL, 8'h00);
        check("flag held", 32'h3, rd);
        wr(IDX_INFRARED_CONTROL, 8'h00);
        bus(1'b0, IDX_INFRARED_CONTROL, 8'h00);
        check("flag cleared", 32'h0, rd);
        $display("Test emission pin %0d done", pin);
    endtask

    task automatic final_report();
        $display("Comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        wait_cycles(20000);
        error_cnt++;
        final_report();
    end

    initial begin
        wait_cycles(2);
        rst_b <= 1'b1;
        foreach (idx_list[i]) begin
            bus(1'b0, idx_list[i], 8'h00);
            check("reset value", 32'h0, rd);
        end
        wr(8'h10, 8'h5a);
        bus(1'b0, 8'h10, 8'h00);
        check("unmapped read", 32'h0, rd);
        wr(IDX_ENVELOPE_COUNT_HI, 8'hff);
        bus(1'b0, IDX_ENVELOPE_COUNT_HI, 8'h00);
        check("count high mask", 32'hbf, rd);
        wr(IDX_ENVELOPE_COUNT_LO, 8'ha5);
        bus(1'b0, IDX_ENVELOPE_COUNT_LO, 8'h00);
        check("count low", 32'ha5, rd);
        wr(IDX_INFRARED_CONTROL, 8'h02);
        bus(1'b0, IDX_INFRARED_CONTROL, 8'h00);
        check("done flag read only", 32'h0, rd);
        $display("Test registers done");
        // Carrier of 20 cycles, 10 high, undivided clock
        wr(IDX_CARRIER_PERIOD_LO, 8'h14);
        wr(IDX_CARRIER_DUTY_LO, 8'h0a);
        strap <= 1'b1;
        wr(IDX_CARRIER_CONTROL, 8'h81);
        e0 = edges;
        wait_cycles(100);
        check("plain carrier edges", 32'h5, {16'h0, edges - e0});
        wr(IDX_CARRIER_CONTROL, 8'h01);
        e0 = edges;
        wait_cycles(100);
        check("stopped carrier edges", 32'h0, {16'h0, edges - e0});
        // Select without pin output enable leaves both pins released
        wr(IDX_CARRIER_CONTROL, 8'h80);
        wr(IDX_ENVELOPE_COUNT_HI, 8'h80);
        wr(IDX_INFRARED_CONTROL, 8'h01);
        wait_cycles(100);
        check("pins off", 32'h0, {30'h0, hs_oe, std_oe});
        wr(IDX_INFRARED_CONTROL, 8'h00);
        $display("Test carrier done");
        // Straps picked before the sink pin is ever driven low
        run_emission(1'b0);
        run_emission(1'b1);
        check("sink pin never high", 32'h0, {31'h0, drove_high});
        final_report();
    end
endmodule
`default_nettype wire
